// *** timer_map.svh ***
// Purpose: register indices, field positions, reset values and timing figures
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

`define TMR_IDX_PRIO      16'hff21
`define TMR_IDX_EN        16'hff23
`define TMR_IDX_FLAG      16'hff25
`define TMR_IDX_GLOBAL    16'hff30
`define TMR_IDX_CTRL_A    16'hff31
`define TMR_IDX_CTRL_B    16'hff32
`define TMR_IDX_RELOAD_A  16'hff33
`define TMR_IDX_RELOAD_B  16'hff34
`define TMR_IDX_COUNT_A   16'hff35
`define TMR_IDX_COUNT_B   16'hff36

`define TMR_POS_PRIO_LO   2
`define TMR_POS_PRIO_HI   3
`define TMR_POS_A         6
`define TMR_POS_B         7
`define TMR_POS_OUT_EN    2
`define TMR_POS_OUT_CHANNEL_SEL     3
`define TMR_POS_CHAIN     4
`define TMR_POS_RUN       0
`define TMR_POS_PRESET    1
`define TMR_POS_CONT      2
`define TMR_POS_EVENT_COUNT_SELECT     7

`define TMR_RST_RELOAD    8'hff
`define TMR_RST_COUNT     8'hff

`define TMR_PCLK_PERIOD_NS 50
`define TMR_LATCH_HOLD_NS  730000

`endif

// *** timer_pkg.sv ***
// Purpose: state types of the dual timer
// Assumes: 8-bit counters
// Notes:   each module keeps its whole state in one struct
package timer_pkg;

   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       s3;
      logic       level;
      logic [7:0] count;
   } stage_type;

   typedef struct packed {
      logic        pready;
      logic [7:0]  prdata;
      logic        pslverr;
      logic [1:0]  prio;
      logic        en_a;
      logic        en_b;
      logic        flag_a;
      logic        flag_b;
      logic        chain;
      logic        out_channel_sel;
      logic        out_en;
      logic        run_req_a;
      logic        run_req_b;
      logic        run_act_a;
      logic        run_act_b;
      logic        cont_a;
      logic        cont_b;
      logic        event_count_select;
      logic [7:0]  reload_a;
      logic [7:0]  reload_b;
      logic [7:0]  latch_b;
      logic        latched;
      logic [15:0] latch_cnt;
      logic        timer_out_signal;
      logic        pin;
      logic        irq;
   } state_type;

endpackage

// *** prescaled_count_stage.sv ***
// Purpose: one 8-bit down counter with its prescaled clock pin synchroniser
// Assumes: clk_pin is asynchronous to pclk
// Notes:   load wins over decrement; decrement below zero wraps
`timescale 1ns/1ns
`include "timer_map.svh"
module prescaled_count_stage
   import timer_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       clk_pin,
   input  wire logic       load,
   input  wire logic [7:0] load_value,
   input  wire logic       dec,
   output logic            tick,
   output logic [7:0]      count
);
   stage_type s;
   stage_type next_s;

   // Falling edge counts once the last two stages agree on low
   assign tick  = s.level && !s.s2 && !s.s3;
   assign count = s.count;

   always_comb begin
      next_s    = s;
      next_s.s1 = clk_pin;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      if (s.s2 == s.s3) begin
         next_s.level = s.s2;
      end
      if (load) begin
         next_s.count = load_value;
      end else if (dec) begin
         next_s.count = s.count - 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s       <= '0;
         s.count <= `TMR_RST_COUNT;
      end else begin
         s <= next_s;
      end
   end
endmodule

// *** dual_timer_ctrl.sv ***
// Purpose: control of two 8-bit down timers, chainable to one 16-bit timer
// Assumes: APB slave on pclk; prescaled clocks arrive as pins
// Notes:   rules carried out here are tagged at their logic
// Behaviour
// RL1: Writing one to preset copies reload value into counter; zero does nothing.
// RL2: Preset while running resumes from new value; while stopped holds it.
// RL3: In chained mode a preset write to the second timer is ignored.
// RL4: Preset bits always read back as zero.
// RL5: Run bit one counts down, zero stops; stopped counter keeps its value.
// RL6: In chained mode the second timer's run bit stays zero.
// RL7: Run bit clears at reset and on one-shot underflow.
// RL8: Run or stop takes effect on next prescaled falling edge, except event mode.
// RL9: After writing zero, run bit reads one until really stopped.
// RL10: Channel select one routes first timer underflow to output, zero second.
// RL11: In chained mode the output follows the 16-bit underflow.
// RL12: Output enable one drives output signal on pin; zero holds pin high.
// RL13: Software keeps the shared pin data bit at one for the output.
// RL14: Priority field encodes levels 3 to 0; zero means no interrupt.
// RL15: Per-timer interrupt enable; first timer's enable ignored in chained mode.
// RL16: Flag sets on underflow regardless of enable and priority.
// RL17: Request only if flag, enable and priority above CPU mask.
// RL18: Writing one clears a flag; zero leaves it; flags reset to zero.
// RL19: Chained mode never sets first flag; 16-bit underflow sets second.
// RL20: Software stops timers and output before sleep.
// RL21: Output gating may glitch up to half a cycle.
// RL22: Software starts fast oscillator and waits before using it.
// RL23: Software reads low byte then high byte within 0.73 ms.
// RL24: Low byte read latches high byte until high read or timeout.
// RL25: Continuous underflow reloads and counts on; one-shot reloads and stops.
// RL26: Mode bit zero gives two 8-bit timers, one gives one 16-bit.
// RL27: Chained low counter borrows into high counter on each underflow.
// RL28: Counter decrements per prescaled edge while running; underflow past zero.
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
`include "timer_map.svh"
module dual_timer_ctrl
   import timer_pkg::*;
#(
   parameter int unsigned LATCH_HOLD_CYCLES =
      (`TMR_LATCH_HOLD_NS + `TMR_PCLK_PERIOD_NS - 1) / `TMR_PCLK_PERIOD_NS
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [17:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        clk_in_a,
   input  wire logic        clk_in_b,
   input  wire logic [1:0]  cpu_mask,
   output logic             irq_request,
   output logic [1:0]       irq_level,
   output logic             shared_out_pin
);
   localparam logic [15:0] HOLD_LAST = 16'(LATCH_HOLD_CYCLES - 1);

   state_type   s;
   state_type   next_s;
   logic [15:0] idx;
   logic [7:0]  wdat;
   logic        acc;
   logic        prep;
   logic        wr;
   logic        preset_a;
   logic        preset_b;
   logic        tick_a;
   logic        tick_b;
   logic [7:0]  cnt_a;
   logic [7:0]  cnt_b;
   logic        adv_a;
   logic        adv_b;
   logic        borrow;
   logic        uf_a;
   logic        uf_b;
   logic        uf16;
   logic        load_a;
   logic        load_b;
   logic        sel_uf;
   logic        req;
   logic [8:0]  view;

   function automatic logic [8:0] read_view(input logic [15:0] i, input state_type st,
                                            input logic [7:0] ca, input logic [7:0] cb);
      logic [8:0] v;
      v = 9'h000;
      unique case (i)
         `TMR_IDX_PRIO:     v = {1'b1, 4'h0, st.prio, 2'h0};
         `TMR_IDX_EN:       v = {1'b1, st.en_b, st.en_a, 6'h00};
         `TMR_IDX_FLAG:     v = {1'b1, st.flag_b, st.flag_a, 6'h00};
         `TMR_IDX_GLOBAL:   v = {1'b1, 3'h0, st.chain, st.out_channel_sel, st.out_en, 2'h0};
         // Preset bit reads zero; run bit shows request or live run
         `TMR_IDX_CTRL_A:   v = {1'b1, st.event_count_select, 4'h0, st.cont_a, 1'b0,
                                 st.run_req_a | st.run_act_a}; // RL4 RL9
         `TMR_IDX_CTRL_B:   v = {1'b1, 5'h00, st.cont_b, 1'b0,
                                 st.run_req_b | st.run_act_b}; // RL4 RL9
         `TMR_IDX_RELOAD_A: v = {1'b1, st.reload_a};
         `TMR_IDX_RELOAD_B: v = {1'b1, st.reload_b};
         `TMR_IDX_COUNT_A:  v = {1'b1, ca};
         `TMR_IDX_COUNT_B:  v = {1'b1, st.latched ? st.latch_b : cb}; // RL24
         default:           v = 9'h000;
      endcase
      return v;
   endfunction

   assign idx  = paddr[17:2];
   assign wdat = pwdata[7:0];
   // One wait state: answer is prepared in the first access cycle
   assign prep = psel && penable && !s.pready;
   assign acc  = psel && penable && s.pready;
   assign wr   = acc && pwrite;
   assign view = read_view(idx, s, cnt_a, cnt_b);

   assign preset_a = wr && idx == `TMR_IDX_CTRL_A && wdat[`TMR_POS_PRESET]; // RL1
   assign preset_b = wr && idx == `TMR_IDX_CTRL_B && wdat[`TMR_POS_PRESET]
                     && !s.chain; // RL3
   assign adv_a  = s.run_act_a && tick_a; // RL28
   assign borrow = adv_a && cnt_a == 8'h00; // RL28
   assign uf16   = s.chain && borrow && cnt_b == 8'h00; // RL27
   assign adv_b  = s.chain ? borrow : (s.run_act_b && tick_b); // RL27 RL26
   assign uf_a   = !s.chain && borrow;
   assign uf_b   = !s.chain && adv_b && cnt_b == 8'h00;
   // Preset applies in any run state, so a running counter carries on
   assign load_a = preset_a || uf_a || uf16; // RL2 RL25
   assign load_b = preset_b || uf_b || uf16 || (s.chain && preset_a); // RL25
   assign sel_uf = s.chain ? uf16 : (s.out_channel_sel ? uf_a : uf_b); // RL10 RL11
   assign req    = (s.flag_a && s.en_a && !s.chain) || (s.flag_b && s.en_b); // RL15

   prescaled_count_stage u_stage_a (
      .pclk       (pclk),
      .presetn    (presetn),
      .clk_pin    (clk_in_a),
      .load       (load_a),
      .load_value (s.reload_a),
      .dec        (adv_a),
      .tick       (tick_a),
      .count      (cnt_a)
   );

   prescaled_count_stage u_stage_b (
      .pclk       (pclk),
      .presetn    (presetn),
      .clk_pin    (clk_in_b),
      .load       (load_b),
      .load_value (s.reload_b),
      .dec        (adv_b),
      .tick       (tick_b),
      .count      (cnt_b)
   );

   always_comb begin
      next_s        = s;
      next_s.pready = prep;
      if (prep) begin
         next_s.prdata  = pwrite ? 8'h00 : view[7:0];
         next_s.pslverr = !view[8];
      end
      if (wr) begin
         unique case (idx)
            `TMR_IDX_PRIO:   next_s.prio = wdat[`TMR_POS_PRIO_HI:`TMR_POS_PRIO_LO];
            `TMR_IDX_EN: begin
               next_s.en_a = wdat[`TMR_POS_A];
               next_s.en_b = wdat[`TMR_POS_B];
            end
            `TMR_IDX_FLAG: begin
               next_s.flag_a = s.flag_a && !wdat[`TMR_POS_A]; // RL18
               next_s.flag_b = s.flag_b && !wdat[`TMR_POS_B]; // RL18
            end
            `TMR_IDX_GLOBAL: begin
               next_s.out_en = wdat[`TMR_POS_OUT_EN];
               next_s.out_channel_sel  = wdat[`TMR_POS_OUT_CHANNEL_SEL];
               next_s.chain  = wdat[`TMR_POS_CHAIN]; // RL26
            end
            `TMR_IDX_CTRL_A: begin
               next_s.run_req_a = wdat[`TMR_POS_RUN]; // RL5
               next_s.cont_a    = wdat[`TMR_POS_CONT];
               next_s.event_count_select     = wdat[`TMR_POS_EVENT_COUNT_SELECT];
            end
            `TMR_IDX_CTRL_B: begin
               next_s.run_req_b = wdat[`TMR_POS_RUN]; // RL5
               next_s.cont_b    = wdat[`TMR_POS_CONT];
            end
            `TMR_IDX_RELOAD_A: next_s.reload_a = wdat;
            `TMR_IDX_RELOAD_B: next_s.reload_b = wdat;
            default: ;
         endcase
      end
      // Hardware set wins over a clear in the same cycle
      next_s.flag_a = next_s.flag_a || uf_a; // RL16 RL19
      next_s.flag_b = next_s.flag_b || uf_b || uf16; // RL16 RL19
      // Run state follows the request on a prescaled falling edge, or at once for the first timer in event mode
      if (s.event_count_select) begin
         next_s.run_act_a = next_s.run_req_a;
      end else if (tick_a) begin
         next_s.run_act_a = s.run_req_a; // RL8
      end
      if (tick_b) begin
         next_s.run_act_b = s.run_req_b; // RL8
      end
      if ((uf_a || uf16) && !s.cont_a) begin
         next_s.run_req_a = 1'b0; // RL7 RL25
         next_s.run_act_a = 1'b0;
      end
      if (uf_b && !s.cont_b) begin
         next_s.run_req_b = 1'b0; // RL7 RL25
         next_s.run_act_b = 1'b0;
      end
      if (next_s.chain) begin
         next_s.run_req_b = 1'b0; // RL6
         next_s.run_act_b = 1'b0;
      end
      // High byte snapshot guards against a borrow between the two reads
      if (s.latched) begin
         next_s.latch_cnt = s.latch_cnt + 16'h0001;
      end
      if ((prep && !pwrite && idx == `TMR_IDX_COUNT_B)
          || (s.latched && s.latch_cnt == HOLD_LAST)) begin
         next_s.latched = 1'b0; // RL24
      end
      if (prep && !pwrite && idx == `TMR_IDX_COUNT_A && s.chain) begin
         next_s.latched   = 1'b1; // RL24
         next_s.latch_b   = cnt_b;
         next_s.latch_cnt = 16'h0000;
      end
      next_s.timer_out_signal = s.timer_out_signal ^ sel_uf; // RL10 RL11
      // Registered gating keeps the pin free of the half-cycle glitch
      next_s.pin  = s.out_en ? s.timer_out_signal : 1'b1; // RL12 RL21
      next_s.irq  = req && (s.prio > cpu_mask); // RL14 RL17
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s          <= '0;
         s.reload_a <= `TMR_RST_RELOAD;
         s.reload_b <= `TMR_RST_RELOAD;
         s.pin      <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign prdata         = {24'h000000, s.prdata};
   assign pready         = s.pready;
   assign pslverr        = s.pslverr;
   assign irq_request    = s.irq;
   assign irq_level      = s.prio;
   assign shared_out_pin = s.pin;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   preset_reads_zero_a: assert property ( // RL4
      prep && !pwrite && (idx == `TMR_IDX_CTRL_A || idx == `TMR_IDX_CTRL_B)
      |=> pready && !prdata[`TMR_POS_PRESET])
      else $error("preset bit read back as one");
   preset_loads_a: assert property ( // RL1
      preset_a && !(wr && idx == `TMR_IDX_RELOAD_A) |=> cnt_a == $past(s.reload_a))
      else $error("preset did not load reload value");
   chain_preset_b_a: assert property ( // RL3
      wr && idx == `TMR_IDX_CTRL_B && wdat[`TMR_POS_PRESET] && s.chain && !adv_b
      && !uf16 && !preset_a |=> $stable(cnt_b))
      else $error("chained preset of second timer took effect");
   chain_run_b_a: assert property ( // RL6
      s.chain |-> !s.run_req_b && !s.run_act_b)
      else $error("second run bit set in chained mode");
   oneshot_stop_a: assert property ( // RL7
      uf_a && !s.cont_a |=> !s.run_req_a && !s.run_act_a)
      else $error("one-shot underflow left timer running");
   stop_on_edge_a: assert property ( // RL8
      s.run_act_a && !s.run_req_a && tick_a && !s.event_count_select && !load_a
      |=> !s.run_act_a && cnt_a == $past(cnt_a) - 8'h01)
      else $error("stop did not land after one decrement");
   run_reads_one_a: assert property ( // RL9
      prep && !pwrite && idx == `TMR_IDX_CTRL_A && s.run_act_a |=> prdata[`TMR_POS_RUN])
      else $error("run bit read zero while running");
   flag_set_b_a: assert property ( // RL16
      uf_b || uf16 |=> s.flag_b)
      else $error("underflow did not set flag");
   flag_clear_b_a: assert property ( // RL18
      wr && idx == `TMR_IDX_FLAG && wdat[`TMR_POS_B] && !uf_b && !uf16 |=> !s.flag_b)
      else $error("write one did not clear flag");
   irq_gate_a: assert property ( // RL17
      !req || s.prio <= cpu_mask |=> !irq_request)
      else $error("interrupt raised without cause");
   chain_flag_a_a: assert property ( // RL19
      s.chain && !s.flag_a |=> !s.flag_a)
      else $error("first flag set in chained mode");
   pin_high_a: assert property ( // RL12
      !s.out_en |=> shared_out_pin)
      else $error("pin not high with output disabled");
   reload_cont_a: assert property ( // RL25
      uf_a && s.cont_a |=> cnt_a == $past(s.reload_a) && s.run_req_a)
      else $error("continuous underflow did not reload");
   preset_loads_b_a: assert property ( // RL1
      preset_b |=> cnt_b == $past(s.reload_b))
      else $error("preset did not load second counter");
   stopped_hold_a: assert property ( // RL2 RL5
      !adv_a && !load_a |=> $stable(cnt_a))
      else $error("stopped counter moved");
   count_dec_a: assert property ( // RL28
      adv_a && !load_a |=> cnt_a == $past(cnt_a) - 8'h01)
      else $error("running counter did not decrement");
   run_on_edge_a: assert property ( // RL8
      !s.run_act_a && s.run_req_a && tick_a && !s.event_count_select |=> s.run_act_a)
      else $error("run did not start on prescaled edge");
   out_sel_a_a: assert property ( // RL10
      !s.chain && s.out_channel_sel && uf_a |=> s.timer_out_signal != $past(s.timer_out_signal))
      else $error("first timer underflow missing on output");
   out_sel_b_a: assert property ( // RL10
      !s.chain && !s.out_channel_sel && uf_a && !uf_b |=> $stable(s.timer_out_signal))
      else $error("unselected underflow reached output");
   chain_out_a: assert property ( // RL11
      uf16 |=> s.timer_out_signal != $past(s.timer_out_signal))
      else $error("chained underflow missing on output");
   pin_follow_a: assert property ( // RL12
      s.out_en |=> shared_out_pin == $past(s.timer_out_signal))
      else $error("pin does not follow output signal");
   prio_write_a: assert property ( // RL14
      wr && idx == `TMR_IDX_PRIO
      |=> irq_level == $past(wdat[`TMR_POS_PRIO_HI:`TMR_POS_PRIO_LO]))
      else $error("priority level not stored");
   chain_en_a_a: assert property ( // RL15
      s.chain && !s.flag_b |=> !irq_request)
      else $error("first timer request in chained mode");
   flag_set_a_a: assert property ( // RL16
      uf_a |=> s.flag_a)
      else $error("underflow did not set first flag");
   irq_raise_a: assert property ( // RL17
      req && s.prio > cpu_mask |=> irq_request)
      else $error("enabled interrupt not raised");
   latched_read_a: assert property ( // RL24
      prep && !pwrite && idx == `TMR_IDX_COUNT_B && s.latched
      |=> prdata[7:0] == $past(s.latch_b))
      else $error("high byte read not taken from latch");
   chain_borrow_a: assert property ( // RL27
      s.chain && borrow && cnt_b != 8'h00 && !preset_a
      |=> cnt_b == $past(cnt_b) - 8'h01)
      else $error("borrow did not reach high counter");

   preset_running_c: cover property (preset_a && s.run_act_a);
   oneshot_c:        cover property (uf_a && !s.cont_a);
   chained_uf_c:     cover property (uf16);
   latch_timeout_c:  cover property (s.latched && s.latch_cnt == HOLD_LAST);
   run_stop_c:       cover property (s.run_act_a && !s.run_req_a && tick_a);
endmodule

// *** tb.sv ***
// Purpose: self-checking bench for the dual timer control block over APB
// Assumes: one APB wait state; prescaled clock edges seen a few pclk after the pin falls
// Notes:   random reload values come from an LFSR with a fixed seed
`timescale 1ns/1ns
module tb;
   import timer_pkg::*;
   `include "timer_map.svh"

   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [17:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        clk_in_a;
   logic        clk_in_b;
   logic [1:0]  cpu_mask;
   logic        irq_request;
   logic [1:0]  irq_level;
   logic        shared_out_pin;
   int          error_cnt;
   int          checked;
   logic [31:0] rnd;
   logic [7:0]  rd_v;
   logic        err_v;
   logic [7:0]  c0;
   logic [7:0]  r;
   logic        p0;
   logic [15:0] ridx [10] = '{`TMR_IDX_PRIO, `TMR_IDX_EN, `TMR_IDX_FLAG, `TMR_IDX_GLOBAL,
      `TMR_IDX_CTRL_A, `TMR_IDX_CTRL_B, `TMR_IDX_RELOAD_A, `TMR_IDX_RELOAD_B,
      `TMR_IDX_COUNT_A, `TMR_IDX_COUNT_B};
   logic [7:0]  rexp [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'hff, 8'hff, 8'hff, 8'hff};

   dual_timer_ctrl #(.LATCH_HOLD_CYCLES(20)) i_dual_timer_ctrl (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .clk_in_a(clk_in_a), .clk_in_b(clk_in_b), .cpu_mask(cpu_mask),
      .irq_request(irq_request), .irq_level(irq_level), .shared_out_pin(shared_out_pin));

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Request held until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd_v  = prdata[7:0];
      err_v = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         error_cnt++;
         test_done();
      end
   endtask

   task automatic rd(input string nm, input logic [15:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00);
      chk(nm, e, rd_v);
   endtask

   // Falling edge on the prescaled pin; held long enough for the synchroniser
   task automatic edges(input int n);
      repeat (n) begin
         rnd = lfsr(rnd);
         clk_in_a <= 1'b0;
         clk_in_b <= rnd[0];
         repeat (6) @(posedge pclk);
         clk_in_a <= 1'b1;
         repeat (6) @(posedge pclk);
      end
   endtask

   // Preset, start one-shot, clock until the given flag bit rises
   task automatic underflow(input logic [7:0] rv, input logic [7:0] fbit);
      int n;
      apb(1'b1, `TMR_IDX_RELOAD_A, rv);
      apb(1'b1, `TMR_IDX_CTRL_A, 8'h02);
      apb(1'b1, `TMR_IDX_CTRL_A, 8'h01);
      n = 0;
      do begin
         edges(1);
         apb(1'b0, `TMR_IDX_FLAG, 8'h00);
         n++;
      end while ((rd_v & fbit) == 8'h00 && n < 40);
      if (n >= 40) begin
         error_cnt++;
         test_done();
      end
   endtask

   initial begin
      repeat (100000) @(posedge pclk);
      error_cnt++;
      test_done();
   end

   initial begin
      error_cnt = 0;
      checked = 0;
      rnd = 32'h45ea;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 18'h00000;
      pwdata = 32'h00000000;
      clk_in_a = 1'b1;
      clk_in_b = 1'b1;
      cpu_mask = 2'b01;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 10; i++) rd("reset value", ridx[i], rexp[i]);
      chk("pin after reset", 8'h01, {7'h00, shared_out_pin});
      apb(1'b0, 16'hff22, 8'h00);
      chk("unmapped error", 8'h01, {7'h00, err_v});
      chk("unmapped data", 8'h00, rd_v);
      // Preset while stopped, then idle clock edges must not move it
      rnd = lfsr(rnd);
      r = rnd[7:0] | 8'h10;
      apb(1'b1, `TMR_IDX_RELOAD_A, r);
      apb(1'b1, `TMR_IDX_CTRL_A, 8'h02);
      rd("preset reads zero", `TMR_IDX_CTRL_A, 8'h00);
      rd("preset count", `TMR_IDX_COUNT_A, r);
      edges(2);
      apb(1'b1, `TMR_IDX_CTRL_A, 8'h00);
      rd("held while stopped", `TMR_IDX_COUNT_A, r);
      // Running count falls one per edge
      apb(1'b1, `TMR_IDX_CTRL_A, 8'h05);
      edges(1);
      apb(1'b0, `TMR_IDX_COUNT_A, 8'h00);
      c0 = rd_v;
      chk("start on edge", r, c0);
      edges(3);
      rd("decrement", `TMR_IDX_COUNT_A, c0 - 8'd3);
      rnd = lfsr(rnd);
      r = rnd[7:0] | 8'h10;
      apb(1'b1, `TMR_IDX_RELOAD_A, r);
      apb(1'b1, `TMR_IDX_CTRL_A, 8'h07);
      rd("preset running", `TMR_IDX_COUNT_A, r);
      edges(1);
      rd("resume after preset", `TMR_IDX_COUNT_A, r - 8'd1);
      // Stop lands after one more decrement
      apb(1'b1, `TMR_IDX_CTRL_A, 8'h04);
      rd("run still reads one", `TMR_IDX_CTRL_A, 8'h05);
      edges(1);
      rd("one more decrement", `TMR_IDX_COUNT_A, r - 8'd2);
      rd("run now zero", `TMR_IDX_CTRL_A, 8'h04);
      edges(2);
      rd("stopped keeps value", `TMR_IDX_COUNT_A, r - 8'd2);
      // One-shot underflow of timer a routed to the pin, interrupt enabled
      apb(1'b1, `TMR_IDX_GLOBAL, 8'h0c);
      repeat (3) @(posedge pclk);
      p0 = shared_out_pin;
      apb(1'b1, `TMR_IDX_PRIO, 8'h08);
      apb(1'b1, `TMR_IDX_EN, 8'h40);
      underflow(8'h03, 8'h40);
      rd("one-shot stops", `TMR_IDX_CTRL_A, 8'h00);
      rd("reload on underflow", `TMR_IDX_COUNT_A, 8'h03);
      chk("pin toggled", {7'h00, ~p0}, {7'h00, shared_out_pin});
      chk("irq level", 8'h02, {6'h00, irq_level});
      chk("irq raised", 8'h01, {7'h00, irq_request});
      cpu_mask <= 2'b10;
      repeat (3) @(posedge pclk);
      chk("irq masked", 8'h00, {7'h00, irq_request});
      cpu_mask <= 2'b01;
      apb(1'b1, `TMR_IDX_FLAG, 8'h00);
      rd("flag kept", `TMR_IDX_FLAG, 8'h40);
      apb(1'b1, `TMR_IDX_FLAG, 8'h40);
      rd("flag cleared", `TMR_IDX_FLAG, 8'h00);
      chk("irq after clear", 8'h00, {7'h00, irq_request});
      // Channel b selected, enable off: flag still sets, pin does not move
      apb(1'b1, `TMR_IDX_GLOBAL, 8'h04);
      apb(1'b1, `TMR_IDX_EN, 8'h00);
      repeat (3) @(posedge pclk);
      p0 = shared_out_pin;
      underflow(8'h02, 8'h40);
      chk("pin unmoved", {7'h00, p0}, {7'h00, shared_out_pin});
      chk("irq disabled", 8'h00, {7'h00, irq_request});
      apb(1'b1, `TMR_IDX_FLAG, 8'h40);
      apb(1'b1, `TMR_IDX_GLOBAL, 8'h00);
      repeat (3) @(posedge pclk);
      chk("pin idle high", 8'h01, {7'h00, shared_out_pin});
      // Chained mode
      apb(1'b1, `TMR_IDX_GLOBAL, 8'h10);
      apb(1'b1, `TMR_IDX_CTRL_B, 8'h01);
      rd("run b forced zero", `TMR_IDX_CTRL_B, 8'h00);
      rnd = lfsr(rnd);
      apb(1'b1, `TMR_IDX_RELOAD_B, rnd[7:0] & 8'h7f);
      apb(1'b1, `TMR_IDX_CTRL_B, 8'h02);
      rd("preset b ignored", `TMR_IDX_COUNT_B, 8'hff);
      apb(1'b1, `TMR_IDX_RELOAD_B, 8'h00);
      apb(1'b1, `TMR_IDX_EN, 8'h80);
      underflow(8'h01, 8'h80);
      rd("only flag b", `TMR_IDX_FLAG, 8'h80);
      chk("chained irq", 8'h01, {7'h00, irq_request});
      // Low byte read freezes the high byte for the following high read
      rnd = lfsr(rnd);
      r = rnd[7:0] | 8'h01;
      apb(1'b1, `TMR_IDX_RELOAD_B, r);
      rd("low byte", `TMR_IDX_COUNT_A, 8'h01);
      apb(1'b1, `TMR_IDX_CTRL_A, 8'h02);
      rd("high byte latched", `TMR_IDX_COUNT_B, 8'h00);
      rd("high byte live", `TMR_IDX_COUNT_B, r);
      apb(1'b1, `TMR_IDX_RELOAD_B, 8'h00);
      rd("low byte again", `TMR_IDX_COUNT_A, 8'h01);
      apb(1'b1, `TMR_IDX_CTRL_A, 8'h02);
      repeat (25) @(posedge pclk);
      rd("latch timeout", `TMR_IDX_COUNT_B, 8'h00);
      apb(1'b1, `TMR_IDX_CTRL_A, 8'h00);
      apb(1'b1, `TMR_IDX_GLOBAL, 8'h00);
      test_done();
   end
endmodule
